/* pfrs_top.v */
/*
  Protection and fault sequencer of an isolated DC/DC module: deglitched
  shutdown, fault pulse on the enable/fault pin, hiccup restart, setpoint
  capture, duty limit and an Avalon-MM register slave with interrupt.
  Assumes all inputs synchronous to clk; the pin is open drain.
*/
// Our own choices: register access over Avalon-MM and the placing of the registers.
`default_nettype none

`include "pfrs_regs.vh"

module pfrs_top #(
  parameter RESTART_CYC = `PFRS_RESTART_CYC
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         irq_reg,
  input  wire        enable_fault_pin_in,
  output reg         enable_fault_pin_out,
  output reg         enable_fault_pin_oe_n,
  input  wire        setpoint_select_to_output,
  input  wire        vout_below_uv,
  input  wire        vout_above_ov,
  input  wire        vout_above_uvlo,
  input  wire        primary_overtemp,
  input  wire        secondary_overtemp,
  input  wire        vin_below_uvlo,
  input  wire        vin_above_ovlo,
  input  wire        burst_start,
  output reg         switching_en_reg,
  output reg  [7:0]  duty_max_reg,
  output reg         power_limit_reg,
  output reg         output_overvoltage_clamp,
  output reg         overtemp_mode_reg,
  output reg         setpoint_5v5_reg,
  output wire [5:0]  freq_code
);

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [2:0]  cause_reg;
  reg [2:0]  cause_next;
  reg [20:0] timer_reg;
  reg [20:0] timer_next;
  reg [31:0] ctrl_reg;
  reg [`PFRS_EV_W-1:0] istat_reg;
  reg [`PFRS_EV_W-1:0] imask_reg;
  reg [`PFRS_EV_W-1:0] ev;

  localparam integer FAULT_LAST_I = `PFRS_FAULT_CYC - 1;

  wire       active;
  wire       uv_exp;
  wire       ov_exp;
  wire       ot_exp;
  wire       hot;
  wire       vin_bad;
  wire       bus_take;
  wire [20:0] fault_last;
  wire [20:0] restart_last;

  assign active       = (state_reg == `PFRS_ST_SOFT) || (state_reg == `PFRS_ST_RUN);
  assign hot          = primary_overtemp | secondary_overtemp;
  assign vin_bad      = vin_below_uvlo | vin_above_ovlo;
  assign bus_take     = (avs_read | avs_write) & ~avs_waitrequest;
  assign fault_last   = FAULT_LAST_I[20:0];
  assign restart_last = RESTART_CYC[20:0] - 21'h000001;

  // Counts in soft-start too, so a standing short hiccups; a ramp must beat it
  pfrs_deglitch #(
    .CYC (`PFRS_DEGLITCH_CYC)
  ) u_uv (
    .clk         (clk),
    .nrst        (nrst),
    .enable      (active),
    .cond        (vout_below_uv),
    .expired_reg (uv_exp)
  );

  pfrs_deglitch #(
    .CYC (`PFRS_DEGLITCH_CYC)
  ) u_ov (
    .clk         (clk),
    .nrst        (nrst),
    .enable      (active),
    .cond        (vout_above_ov),
    .expired_reg (ov_exp)
  );

  pfrs_deglitch #(
    .CYC (`PFRS_DEGLITCH_CYC)
  ) u_ot (
    .clk         (clk),
    .nrst        (nrst),
    .enable      (active),
    .cond        (hot),
    .expired_reg (ot_exp)
  );

  pfrs_ssm u_ssm (
    .clk           (clk),
    .nrst          (nrst),
    .burst_start   (burst_start & switching_en_reg),
    .freq_code_reg (freq_code)
  );

  // Sequencer
  always @*
  begin
    state_next = state_reg;
    cause_next = cause_reg;
    timer_next = timer_reg;
    ev         = {`PFRS_EV_W{1'b0}};
    case (state_reg)
      `PFRS_ST_OFF:
      begin
        if (enable_fault_pin_in)
        begin
          state_next = vin_bad ? `PFRS_ST_LOCK : `PFRS_ST_SOFT;
        end
      end
      `PFRS_ST_SOFT, `PFRS_ST_RUN:
      begin
        timer_next = 21'h000000;
        if (!enable_fault_pin_in)
          state_next = `PFRS_ST_OFF;
        else if (vin_above_ovlo)
        begin
          state_next    = `PFRS_ST_PULSE;
          cause_next    = `PFRS_CS_VINOV;
          ev[`PFRS_EV_VIN] = 1'b1;
        end
        else if (vin_below_uvlo)
        begin
          // No report for input under-voltage
          state_next    = `PFRS_ST_LOCK;
          ev[`PFRS_EV_VIN] = 1'b1;
        end
        else if (ot_exp)
        begin
          state_next    = `PFRS_ST_PULSE;
          cause_next    = `PFRS_CS_OT;
          ev[`PFRS_EV_OT] = 1'b1;
        end
        else if (ov_exp)
        begin
          state_next    = `PFRS_ST_PULSE;
          cause_next    = `PFRS_CS_OV;
          ev[`PFRS_EV_OV] = 1'b1;
        end
        else if (uv_exp)
        begin
          state_next    = `PFRS_ST_PULSE;
          cause_next    = `PFRS_CS_UV;
          ev[`PFRS_EV_UV] = 1'b1;
        end
        else if (state_reg == `PFRS_ST_SOFT && vout_above_uvlo && !vout_below_uv)
        begin
          state_next    = `PFRS_ST_RUN;
          ev[`PFRS_EV_REG] = 1'b1;
        end
      end
      `PFRS_ST_PULSE:
      begin
        // While reporting is on the pin reads low from our own sink; enable is ignored here either way
        if (timer_reg == fault_last)
        begin
          timer_next = 21'h000000;
          state_next = (cause_reg == `PFRS_CS_VINOV) ? `PFRS_ST_LOCK : `PFRS_ST_WAIT;
        end
        else
          timer_next = timer_reg + 21'h000001;
      end
      `PFRS_ST_WAIT:
      begin
        if (!enable_fault_pin_in)
          state_next = `PFRS_ST_OFF;
        else if (timer_reg == restart_last)
        begin
          timer_next = 21'h000000;
          state_next = `PFRS_ST_SOFT;
          ev[`PFRS_EV_RESTART] = 1'b1;
        end
        else
          timer_next = timer_reg + 21'h000001;
      end
      `PFRS_ST_LOCK:
      begin
        if (!enable_fault_pin_in)
          state_next = `PFRS_ST_OFF;
        else if (!vin_bad)
          state_next = `PFRS_ST_SOFT;
      end
      default:
        state_next = `PFRS_ST_OFF;
    endcase
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= `PFRS_ST_OFF;
      cause_reg <= `PFRS_CS_UV;
      timer_reg <= 21'h000000;
    end
    else
    begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      timer_reg <= timer_next;
    end
  end

  // Power stage controls
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      switching_en_reg         <= 1'b0;
      duty_max_reg             <= `PFRS_DUTY_CAP;
      power_limit_reg          <= 1'b0;
      output_overvoltage_clamp <= 1'b0;
      overtemp_mode_reg        <= 1'b0;
      setpoint_5v5_reg         <= 1'b0;
    end
    else
    begin
      // Off, pulse, wait and lockout all leave the output at 0V
      switching_en_reg <= (state_next == `PFRS_ST_SOFT) ||
                          (state_next == `PFRS_ST_RUN);
      // Follows the next state so the first switching cycle is already capped
      if ((state_next == `PFRS_ST_SOFT && !vout_above_uvlo) ||
          (state_next == `PFRS_ST_RUN && (vout_below_uv || vout_above_ov)))
        duty_max_reg <= `PFRS_DUTY_CAP;
      else
        duty_max_reg <= `PFRS_DUTY_FULL;
      power_limit_reg          <= (state_reg == `PFRS_ST_RUN) & vout_below_uv;
      output_overvoltage_clamp <= active & vout_above_ov;
      overtemp_mode_reg        <= active & hot;
      // Select is read only before the output passes lockout
      if (state_reg == `PFRS_ST_SOFT && !vout_above_uvlo)
        setpoint_5v5_reg <= ~setpoint_select_to_output;
    end
  end

  // Open-drain fault report; reporting can be switched off by software
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_fault_pin_out  <= 1'b0;
      enable_fault_pin_oe_n <= 1'b1;
    end
    else
    begin
      enable_fault_pin_out  <= 1'b0;
      enable_fault_pin_oe_n <= ~((state_next == `PFRS_ST_PULSE) &
                                 ctrl_reg[`PFRS_CTRL_REPORT]);
    end
  end

  // Avalon-MM slave: one wait cycle, then the answer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_reg        <= `PFRS_CTRL_RESET;
      imask_reg       <= {`PFRS_EV_W{1'b0}};
      istat_reg       <= {`PFRS_EV_W{1'b0}};
      irq_reg         <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) & avs_waitrequest)
      begin
        case (avs_address)
          `PFRS_CTRL_OFS:   avs_readdata <= ctrl_reg;
          `PFRS_STATUS_OFS: avs_readdata <= {22'h000000, setpoint_5v5_reg, overtemp_mode_reg,
                                             power_limit_reg, switching_en_reg,
                                             cause_reg, state_reg};
          `PFRS_ISTAT_OFS:  avs_readdata <= {26'h0000000, istat_reg};
          `PFRS_IMASK_OFS:  avs_readdata <= {26'h0000000, imask_reg};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (bus_take & avs_write & (avs_address == `PFRS_CTRL_OFS))
        ctrl_reg <= {31'h00000000, avs_writedata[`PFRS_CTRL_REPORT]};
      if (bus_take & avs_write & (avs_address == `PFRS_IMASK_OFS))
        imask_reg <= avs_writedata[`PFRS_EV_W-1:0];
      // A new event wins over a clear in the same cycle
      if (bus_take & avs_write & (avs_address == `PFRS_ISTAT_OFS))
        istat_reg <= (istat_reg & ~avs_writedata[`PFRS_EV_W-1:0]) | ev;
      else
        istat_reg <= istat_reg | ev;
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

endmodule

`default_nettype wire

/* pfrs_regs.vh */
/*
  Constants of the fault and restart sequencer: register offsets, field
  positions, reset values, state codes and timing counts.
  Assumes a 10 MHz clock; counts are derived from the printed times.
*/
`ifndef PFRS_REGS_VH
`define PFRS_REGS_VH

// Clock rate
`define PFRS_CLK_MHZ        10
`define PFRS_CLK_KHZ        10000

// Times in their own units
`define PFRS_FAULT_US       200
`define PFRS_RESTART_MS     160
`define PFRS_DEGLITCH_US    50

// Cycle counts (pulse exact, deglitch least time)
`define PFRS_FAULT_CYC      (`PFRS_FAULT_US * `PFRS_CLK_MHZ)
`define PFRS_RESTART_CYC    (`PFRS_RESTART_MS * `PFRS_CLK_KHZ)
`define PFRS_DEGLITCH_CYC   (`PFRS_DEGLITCH_US * `PFRS_CLK_MHZ)

// Duty limits in 1/256 steps: 62.5 % and unlimited
`define PFRS_DUTY_CAP       8'hA0
`define PFRS_DUTY_FULL      8'hFF

// Frequency sweep bands
`define PFRS_FREQ_LOW       6'h08
`define PFRS_FREQ_HIGH      6'h37

// Register byte offsets
`define PFRS_CTRL_OFS       5'h00
`define PFRS_STATUS_OFS     5'h04
`define PFRS_ISTAT_OFS      5'h08
`define PFRS_IMASK_OFS      5'h0C

// Control fields
`define PFRS_CTRL_REPORT    0
`define PFRS_CTRL_RESET     32'h0000_0001

// Event bits of interrupt status and mask
`define PFRS_EV_UV          0
`define PFRS_EV_OV          1
`define PFRS_EV_OT          2
`define PFRS_EV_VIN         3
`define PFRS_EV_RESTART     4
`define PFRS_EV_REG         5
`define PFRS_EV_W           6

// Sequencer states
`define PFRS_ST_OFF         3'h0
`define PFRS_ST_SOFT        3'h1
`define PFRS_ST_RUN         3'h2
`define PFRS_ST_PULSE       3'h3
`define PFRS_ST_WAIT        3'h4
`define PFRS_ST_LOCK        3'h5

// Shutdown causes
`define PFRS_CS_UV          3'h0
`define PFRS_CS_OV          3'h1
`define PFRS_CS_OT          3'h2
`define PFRS_CS_VINOV       3'h3

`endif

/* pfrs_deglitch.v */
/*
  Deglitch counter: raises its output once the condition has held for
  CYC consecutive cycles while enabled.
  Assumes a condition synchronous to clk.
*/
`default_nettype none

module pfrs_deglitch #(
  parameter CYC = 500
) (
  input  wire clk,
  input  wire nrst,
  input  wire enable,
  input  wire cond,
  output reg  expired_reg
);

  reg [11:0] cnt_reg;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg     <= 12'h000;
      expired_reg <= 1'b0;
    end
    else if (!enable || !cond)
    begin
      // A glitch that vanishes early starts the count afresh
      cnt_reg     <= 12'h000;
      expired_reg <= 1'b0;
    end
    else if (cnt_reg == CYC[11:0] - 12'h001)
      expired_reg <= 1'b1;
    else
      cnt_reg <= cnt_reg + 12'h001;
  end

endmodule

`default_nettype wire

/* pfrs_ssm.v */
/*
  Spread spectrum sweep: at each burst start the frequency code restarts
  at the low band and climbs one step a cycle to the high band.
  Assumes burst_start is a one-cycle pulse.
*/
`default_nettype none

`include "pfrs_regs.vh"

module pfrs_ssm (
  input  wire       clk,
  input  wire       nrst,
  input  wire       burst_start,
  output reg  [5:0] freq_code_reg
);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      freq_code_reg <= `PFRS_FREQ_LOW;
    else if (burst_start)
      freq_code_reg <= `PFRS_FREQ_LOW;
    else if (freq_code_reg != `PFRS_FREQ_HIGH)
      // Climbs to the high band and holds there; a burst that comes earlier cuts the span short
      freq_code_reg <= freq_code_reg + 6'h01;
  end

endmodule

`default_nettype wire

/* pfrs_mcu_model.sv */
/*
  Monitoring controller on the enable/fault pin.
  Assumes a series resistor on the pin, so the device sink always wins.
*/
`default_nettype none
module pfrs_mcu_model (
  input  wire logic clk,
  input  wire logic drive_en,
  input  wire logic dut_oe_n,
  output wire logic pin,
  output var  int   last_low,
  output var  int   reports
);
  timeunit 1ns;
  timeprecision 1ns;
  int run = 0;
  // Controller drives the pin itself, never leaves it open
  assign pin = dut_oe_n ? drive_en : 1'b0;
  // A low seen while driving high is a shutdown report
  always @(posedge clk)
  begin
    if (!pin && drive_en)
      run <= run + 1;
    else if (run != 0)
    begin
      last_low <= run;
      reports <= reports + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* pfrs_monitor.sv */
/*
  Checker on the sequencer ports.
  Assumes it is bound into pfrs_top with the same RESTART_CYC.
*/
`default_nettype none
`include "pfrs_regs.vh"
module pfrs_monitor #(
  parameter int RESTART_CYC = 50
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       enable_fault_pin_in,
  input wire logic       enable_fault_pin_oe_n,
  input wire logic       vout_below_uv,
  input wire logic       vout_above_ov,
  input wire logic       vout_above_uvlo,
  input wire logic       primary_overtemp,
  input wire logic       secondary_overtemp,
  input wire logic       vin_above_ovlo,
  input wire logic       burst_start,
  input wire logic       switching_en_reg,
  input wire logic [7:0] duty_max_reg,
  input wire logic       output_overvoltage_clamp,
  input wire logic [5:0] freq_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        fault_any;
  logic [11:0] lo_cnt;
  logic [10:0] f_cnt;
  logic [31:0] w_cnt;
  logic        pulsed;
  assign fault_any = vout_below_uv | vout_above_ov | primary_overtemp | secondary_overtemp;
  // Saturating fault count, so a long hiccup never wraps it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lo_cnt <= 12'h000;
      f_cnt <= 11'h000;
      w_cnt <= 32'h0;
      pulsed <= 1'b0;
    end
    else
    begin
      lo_cnt <= enable_fault_pin_oe_n ? 12'h000 : lo_cnt + 12'h001;
      f_cnt <= !fault_any ? 11'h000 : f_cnt + {10'h000, f_cnt != 11'h7FF};
      w_cnt <= !enable_fault_pin_oe_n ? 32'h0 : w_cnt + {31'h0, !switching_en_reg};
      pulsed <= !enable_fault_pin_oe_n |
                (pulsed & !(switching_en_reg | !enable_fault_pin_in | vin_above_ovlo));
    end
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_pulse;
    $rose(enable_fault_pin_oe_n) |-> lo_cnt == 12'h7D0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_sink;
    !enable_fault_pin_oe_n |-> !switching_en_reg;
  endproperty
  a_sink: assert property (p_sink) else $error("switching in pulse");
  property p_restart;
    $rose(switching_en_reg) && pulsed |-> w_cnt == RESTART_CYC;
  endproperty
  a_restart: assert property (p_restart) else $error("restart delay");
  property p_deglitch;
    $fell(enable_fault_pin_oe_n) && !vin_above_ovlo |-> f_cnt >= 11'h1F4;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("early shutdown");
  property p_enable;
    !enable_fault_pin_in && enable_fault_pin_oe_n |=> !switching_en_reg;
  endproperty
  a_enable: assert property (p_enable) else $error("runs while disabled");
  property p_duty;
    switching_en_reg && !vout_above_uvlo ##1 switching_en_reg |-> duty_max_reg == `PFRS_DUTY_CAP;
  endproperty
  a_duty: assert property (p_duty) else $error("duty not capped");
  property p_clamp;
    vout_above_ov && switching_en_reg ##1 switching_en_reg |-> output_overvoltage_clamp;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp off");
  property p_burst;
    burst_start && switching_en_reg |=> freq_code == `PFRS_FREQ_LOW;
  endproperty
  a_burst: assert property (p_burst) else $error("sweep start");
endmodule
bind pfrs_top pfrs_monitor #(
  .RESTART_CYC (RESTART_CYC)
) u_mon (
  .clk                      (clk),
  .nrst                     (nrst),
  .enable_fault_pin_in      (enable_fault_pin_in),
  .enable_fault_pin_oe_n    (enable_fault_pin_oe_n),
  .vout_below_uv            (vout_below_uv),
  .vout_above_ov            (vout_above_ov),
  .vout_above_uvlo          (vout_above_uvlo),
  .primary_overtemp         (primary_overtemp),
  .secondary_overtemp       (secondary_overtemp),
  .vin_above_ovlo           (vin_above_ovlo),
  .burst_start              (burst_start),
  .switching_en_reg         (switching_en_reg),
  .duty_max_reg             (duty_max_reg),
  .output_overvoltage_clamp (output_overvoltage_clamp),
  .freq_code                (freq_code)
);
`default_nettype wire

/* pfrs_tb.sv */
/*
  Bench of the sequencer: register table, start-up, faults, lockouts.
  Assumes pfrs_top, the controller model and the bound checker.
*/
`default_nettype none
`include "pfrs_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
`define WAITFOR(c, n) begin k = 0; while ((c) !== 1'b1 && k < (n)) begin \
  @(posedge clk); k++; end if ((c) !== 1'b1) begin fails++; finish_test(); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RCYC = 50;
  typedef struct packed {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} pfrs_row_t;
  logic        clk, nrst, avs_read, avs_write, drive_en, burst_start;
  logic        setpoint_select_to_output, vout_below_uv, vout_above_ov, vout_above_uvlo;
  logic        primary_overtemp, secondary_overtemp, vin_below_uvlo, vin_above_ovlo;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, rd;
  wire         avs_waitrequest, irq_reg, enable_fault_pin_in, enable_fault_pin_out;
  wire         enable_fault_pin_oe_n, switching_en_reg, power_limit_reg;
  wire         output_overvoltage_clamp, overtemp_mode_reg, setpoint_5v5_reg;
  wire [31:0]  avs_readdata;
  wire [7:0]   duty_max_reg;
  wire [5:0]   freq_code;
  int          fails, samples_checked, k, r0, last_low, reports;
  pfrs_row_t   rows [11];
  pfrs_top #(.RESTART_CYC(RCYC)) u_dut (.*);
  pfrs_mcu_model u_mcu (.clk(clk), .drive_en(drive_en), .dut_oe_n(enable_fault_pin_oe_n),
    .pin(enable_fault_pin_in), .last_low(last_low), .reports(reports));
  always #50 clk = ~clk;
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    `WAITFOR(!avs_waitrequest, 20)
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fault(input logic [3:0] m, input logic [2:0] c);
    {secondary_overtemp, primary_overtemp, vout_above_ov, vout_below_uv} <= m;
    repeat (2) @(posedge clk);
    `CHK("limit", m[0], power_limit_reg)
    `CHK("clamp", m[1], output_overvoltage_clamp)
    `CHK("hot", |m[3:2], overtemp_mode_reg)
    `CHK("duty", (|m[1:0]) ? 8'hA0 : 8'hFF, duty_max_reg)
    `WAITFOR(!enable_fault_pin_oe_n, 600)
    `CHK("deglitch", 1'b1, k > 497)
    // Every cause, under-voltage too, must shut down again on restart
    `WAITFOR(enable_fault_pin_oe_n, 2100)
    `WAITFOR(switching_en_reg, 2100)
    `WAITFOR(!enable_fault_pin_oe_n, 600)
    `CHK("hiccup", 1'b1, k > 497)
    bus(1'h0, 5'h04, 32'h0);
    `CHK("status", {c, 3'h3}, rd[5:0])
    bus(1'h0, 5'h08, 32'h0);
    `CHK("event", 1'b1, rd[c])
    `CHK("irq", c != 3'h1, irq_reg)
    {secondary_overtemp, primary_overtemp, vout_above_ov, vout_below_uv} <= 4'h0;
    bus(1'h1, 5'h08, 32'h3F);
    @(posedge clk);
    `CHK("irq clear", 1'b0, irq_reg)
    `WAITFOR(enable_fault_pin_oe_n, 2100)
    `WAITFOR(switching_en_reg, 100)
    `CHK("restart", RCYC, k)
    `CHK("pulse", 2000, last_low)
    repeat (3) @(posedge clk);
    bus(1'h0, 5'h04, 32'h0);
    `CHK("run", 3'h2, rd[2:0])
    $display("test fault %0h done", m);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    {nrst, avs_read, avs_write, drive_en, burst_start, vout_below_uv, vout_above_ov,
     vout_above_uvlo, primary_overtemp, secondary_overtemp, vin_below_uvlo,
     vin_above_ovlo} = '0;
    setpoint_select_to_output = 1'b1;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    rows = '{'{1'h0, 5'h00, 32'h0, 32'h1}, '{1'h0, 5'h04, 32'h0, 32'h0},
      '{1'h0, 5'h08, 32'h0, 32'h0}, '{1'h0, 5'h0C, 32'h0, 32'h0},
      '{1'h1, 5'h10, 32'hFFFFFFFF, 32'h0}, '{1'h0, 5'h10, 32'h0, 32'h0},
      '{1'h1, 5'h0C, 32'hFFFFFFFF, 32'h0}, '{1'h0, 5'h0C, 32'h0, 32'h3F},
      '{1'h1, 5'h04, 32'hFFFFFFFF, 32'h0}, '{1'h0, 5'h04, 32'h0, 32'h0},
      '{1'h1, 5'h0C, 32'h5, 32'h0}};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        `CHK("reg", rows[i].e, rd)
    end
    $display("test registers done");
    drive_en <= 1'b1;
    `WAITFOR(switching_en_reg, 20)
    `CHK("soft duty", 8'hA0, duty_max_reg)
    vout_above_uvlo <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("run duty", 8'hFF, duty_max_reg)
    `CHK("setpoint", 1'b0, setpoint_5v5_reg)
    burst_start <= 1'b1;
    @(posedge clk);
    burst_start <= 1'b0;
    @(posedge clk);
    `CHK("sweep low", 6'h08, freq_code)
    repeat (47) @(posedge clk);
    `CHK("sweep high", 6'h37, freq_code)
    primary_overtemp <= 1'b1;
    repeat (400) @(posedge clk);
    primary_overtemp <= 1'b0;
    repeat (400) @(posedge clk);
    `CHK("glitch", 0, reports)
    $display("test start done");
    for (int i = 0; i < 4; i++)
      fault(4'h1 << i, (i == 3) ? 3'h2 : 3'(i));
    r0 = reports;
    vin_below_uvlo <= 1'b1;
    repeat (600) @(posedge clk);
    `CHK("uv lock", 1'b0, switching_en_reg)
    `CHK("no report", r0, reports)
    vin_below_uvlo <= 1'b0;
    `WAITFOR(switching_en_reg, 20)
    `CHK("resume", 1'b1, k < 3)
    vin_above_ovlo <= 1'b1;
    `WAITFOR(!enable_fault_pin_oe_n, 600)
    `WAITFOR(enable_fault_pin_oe_n, 2100)
    @(posedge clk);
    `CHK("vin report", r0 + 1, reports)
    vin_above_ovlo <= 1'b0;
    `WAITFOR(switching_en_reg, 20)
    drive_en <= 1'b0;
    setpoint_select_to_output <= 1'b0;
    vout_above_uvlo <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("disabled", 1'b0, switching_en_reg)
    drive_en <= 1'b1;
    `WAITFOR(switching_en_reg, 20)
    repeat (2) @(posedge clk);
    `CHK("setpoint", 1'b1, setpoint_5v5_reg)
    $display("test lockout and enable done");
    // Reporting off: the shutdown still runs while the pin stays released
    bus(1'h1, 5'h00, 32'h0);
    r0 = reports;
    vout_above_ov <= 1'b1;
    `WAITFOR(!switching_en_reg, 600)
    bus(1'h0, 5'h04, 32'h0);
    `CHK("quiet state", {3'h1, 3'h3}, rd[5:0])
    `CHK("quiet pin", 1'b1, enable_fault_pin_oe_n)
    `CHK("pin out", 1'b0, enable_fault_pin_out)
    vout_above_ov <= 1'b0;
    nrst <= 1'b0;
    @(posedge clk);
    `CHK("rst switching", 1'b0, switching_en_reg)
    `CHK("rst duty", `PFRS_DUTY_CAP, duty_max_reg)
    `CHK("rst sweep", `PFRS_FREQ_LOW, freq_code)
    `CHK("rst wait", 1'b1, avs_waitrequest)
    nrst <= 1'b1;
    bus(1'h0, 5'h00, 32'h0);
    `CHK("rst ctrl", `PFRS_CTRL_RESET, rd)
    `CHK("quiet reports", r0, reports)
    $display("test quiet fault and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
